// file: hdl/lpmc_regs.vh
// constants for the low power mode controller: offsets, fields, resets,
// mode codes and timing counts; assumes an 8-bit plain register port.
// Summary of operation
// - sleep: high osc, core, peripherals off; timer on
// - sleep entered and left like idle
// - sleep exit resumes low run, high osc off
// - sleep/idle: only base timer clocked, core halted
// - timer-only modes exit on selected source fall
// - stop halts everything including both oscillators
// - stop/sleep peripherals freeze or reset
// - writing one to halt-request bit enters stop
// - wake plus warm-up returns to previous mode
// - stop retains memory, registers, status word
// - port hold enable governs latches in stop
// - stop entry clears prescaler and divider
// - stop holds address two instructions ahead
// - reset ends stop; then single high run
// - wake by pin, key wakeup, voltage detect
// - timing-gen halt bit enters high idle from N1 run, sleep from S1 run
// - level release: wake pin high leaves stop
// - edge release: wake pin rise leaves stop
`ifndef LPMC_REGS_VH
`define LPMC_REGS_VH
`define LPMC_A_SC1 3'h0
`define LPMC_A_SC2 3'h1
`define LPMC_A_TBC 3'h2
`define LPMC_A_WUC 3'h3
`define LPMC_A_STAT 3'h4
`define LPMC_A_DIV 3'h5
`define LPMC_SC1_STOP 7
`define LPMC_SC1_WAKE_RELEASE_STYLE 6
`define LPMC_SC1_HOLD 4
`define LPMC_SC2_HFEN 7
`define LPMC_SC2_LFEN 6
`define LPMC_SC2_LOW 5
`define LPMC_SC2_TGH 2
`define LPMC_SC1_RST 8'h00
`define LPMC_SC2_RST 8'h80
`define LPMC_TBC_RST 3'h0
`define LPMC_WUC_RST 8'h04
`define LPMC_LF_LAST 2'h3
`define LPMC_WU_UNIT 16'h0010
`define LPMC_M_N1 3'h0
`define LPMC_M_N2 3'h1
`define LPMC_M_S2 3'h2
`define LPMC_M_S1 3'h3
`define LPMC_M_HIGH_CLOCK_TIMER_ONLY_IDLE 3'h4
`define LPMC_M_LOW_CLOCK_TIMER_ONLY_SLEEP 3'h5
`define LPMC_M_STOP 3'h6
`define LPMC_M_WARM 3'h7
`endif

// file: hdl/lpmc_warmup.v
// warm-up timer: counts count*UNIT clock cycles after a start pulse.
// assumes start is a one-cycle pulse from the controller.
`timescale 1ns/10ps
`default_nettype none
module lpmc_warmup #(
    parameter [15:0] UNIT = 16'h0010
) (
    input wire clk,
    input wire rst,
    input wire start,
    input wire [7:0] count,
    output reg done
);
    reg busy;
    reg [7:0] left;
    reg [15:0] sub;

    always @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
            left <= 8'h00;
            sub <= 16'h0000;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy <= 1'b1;
                left <= count;
                sub <= UNIT - 16'h0001;
            end else if (busy) begin
                if (left == 8'h00) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else if (sub == 16'h0000) begin
                    sub <= UNIT - 16'h0001;
                    left <= left - 8'h01;
                end else begin
                    sub <= sub - 16'h0001;
                end
            end
        end
    end
endmodule // lpmc_warmup
`default_nettype wire

// file: hdl/lpmc_top.v
// low power mode controller: run, timer-only idle/sleep, stop, warm-up.
// assumes all inputs synchronous to CLK_SYS and a core that stalls on
// CORE_CLK_EN low and reports the halt-request instruction address.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "lpmc_regs.vh"
module lpmc_top #(
    parameter DIV_W = 16,
    parameter [15:0] WU_UNIT = `LPMC_WU_UNIT
) (
    input wire CLK_SYS,
    input wire RST,
    input wire [2:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [7:0] RDATA,
    input wire LF_CLK,
    input wire WAKE_PIN,
    input wire KEY_WAKE,
    input wire VOLT_WAKE,
    input wire RESET_SRC,
    input wire [15:0] INSN_ADDR,
    output reg HF_OSC_EN,
    output reg LF_OSC_EN,
    output reg CORE_CLK_EN,
    output reg PERIPH_CLK_EN,
    output reg TBT_CLK_EN,
    output reg PERIPH_FREEZE,
    output reg RETAIN,
    output reg PORT_HOLD,
    output reg [15:0] PC_HOLD,
    output reg RESUME,
    output reg [2:0] MODE
);
    localparam [1:0] S_RUN = 2'h0;
    localparam [1:0] S_TONLY = 2'h1;
    localparam [1:0] S_STOP = 2'h2;
    localparam [1:0] S_WARM = 2'h3;
    localparam [7:0] SC1_RST = `LPMC_SC1_RST;
    localparam [7:0] SC2_RST = `LPMC_SC2_RST;

    // run mode from the clock-gear bits
    function [2:0] run_mode;
        input low;
        input hf;
        input lf;
        begin
            if (low) begin
                run_mode = hf ? `LPMC_M_S2 : `LPMC_M_S1;
            end else begin
                run_mode = lf ? `LPMC_M_N2 : `LPMC_M_N1;
            end
        end
    endfunction

    // divider stage picked by the base timer clock select
    function [3:0] tb_idx;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: tb_idx = 4'hF;
                3'h1: tb_idx = 4'hD;
                3'h2: tb_idx = 4'hB;
                3'h3: tb_idx = 4'h9;
                3'h4: tb_idx = 4'h7;
                3'h5: tb_idx = 4'h5;
                3'h6: tb_idx = 4'h3;
                3'h7: tb_idx = 4'h1;
                default: tb_idx = 4'hF;
            endcase
        end
    endfunction

    wire rst_all;
    reg [1:0] state;
    reg [1:0] next_state;
    reg stop_req;
    reg wake_release_style;
    reg hold_en;
    reg hf_en;
    reg lf_en;
    reg low_sel;
    reg [2:0] tb_sel;
    reg [7:0] wu_count;
    reg [2:0] ret_mode;
    reg ret_hf;
    reg ret_lf;
    reg ret_low;
    reg [DIV_W-1:0] div;
    reg tb_prev;
    reg lf_prev;
    reg [1:0] lf_cnt;
    reg wake_prev;
    reg warm_go;
    reg warm_reset;
    reg resume_evt;
    wire warm_done;
    wire lf_rise;
    wire lf_q;
    wire div_en;
    wire tb_bit;
    wire tb_fall;
    wire stop_wake;
    wire stop_ok;
    wire [2:0] cur_mode;
    wire [2:0] now_run;

    assign rst_all = RST | RESET_SRC;
    assign now_run = run_mode(low_sel, hf_en, lf_en);
    assign cur_mode = (state == S_RUN) ? now_run :
                      (state == S_TONLY) ?
                      (low_sel ? `LPMC_M_LOW_CLOCK_TIMER_ONLY_SLEEP : `LPMC_M_HIGH_CLOCK_TIMER_ONLY_IDLE) :
                      (state == S_STOP) ? `LPMC_M_STOP : `LPMC_M_WARM;

    // quarter of the low-frequency clock
    assign lf_rise = LF_CLK & ~lf_prev;
    assign lf_q = lf_rise & (lf_cnt == `LPMC_LF_LAST);

    always @(posedge CLK_SYS) begin
        if (rst_all) begin
            lf_prev <= 1'b0;
            lf_cnt <= 2'h0;
        end else begin
            lf_prev <= LF_CLK;
            if (lf_rise) begin
                lf_cnt <= lf_cnt + 2'h1;
            end
        end
    end

    // divider runs on the gear clock or on a quarter of the low clock
    assign div_en = ((state == S_RUN) | (state == S_TONLY)) &
                    (low_sel ? lf_q : 1'b1);
    assign tb_bit = div[tb_idx(tb_sel)];
    assign tb_fall = tb_prev & ~tb_bit;

    always @(posedge CLK_SYS) begin
        if (rst_all) begin
            div <= {DIV_W{1'b0}};
            tb_prev <= 1'b0;
        end else if (next_state == S_STOP && state == S_RUN) begin
            div <= {DIV_W{1'b0}};
            tb_prev <= 1'b0;
        end else begin
            if (div_en) begin
                div <= div + {{(DIV_W-1){1'b0}}, 1'b1};
            end
            tb_prev <= tb_bit;
        end
    end

    // stop release: level or rising edge on the wake pin, key, voltage
    assign stop_wake = (wake_release_style ? WAKE_PIN : (WAKE_PIN & ~wake_prev)) |
                       KEY_WAKE | VOLT_WAKE;
    // level release refuses to start while the wake pin is high
    assign stop_ok = ~(WDATA[`LPMC_SC1_WAKE_RELEASE_STYLE] & WAKE_PIN);

    always @* begin
        next_state = state;
        case (state)
            S_RUN: begin
                if (WR && ADDR == `LPMC_A_SC1 &&
                    WDATA[`LPMC_SC1_STOP] && stop_ok) begin
                    next_state = S_STOP;
                end else if (WR && ADDR == `LPMC_A_SC2 &&
                             WDATA[`LPMC_SC2_TGH] &&
                             (now_run == `LPMC_M_N1 ||
                              now_run == `LPMC_M_S1)) begin
                    next_state = S_TONLY;
                end
            end
            S_TONLY: begin
                if (tb_fall) begin
                    next_state = S_RUN;
                end
            end
            S_STOP: begin
                if (stop_wake) begin
                    next_state = S_WARM;
                end
            end
            S_WARM: begin
                if (warm_done) begin
                    next_state = S_RUN;
                end
            end
            default: next_state = S_RUN;
        endcase
    end

    // control registers and mode state
    always @(posedge CLK_SYS) begin
        if (rst_all) begin
            state <= S_WARM;
            stop_req <= SC1_RST[`LPMC_SC1_STOP];
            wake_release_style <= 1'b0;
            hold_en <= 1'b0;
            hf_en <= SC2_RST[`LPMC_SC2_HFEN];
            lf_en <= 1'b0;
            low_sel <= 1'b0;
            tb_sel <= `LPMC_TBC_RST;
            wu_count <= `LPMC_WUC_RST;
            ret_mode <= `LPMC_M_N1;
            ret_hf <= 1'b1;
            ret_lf <= 1'b0;
            ret_low <= 1'b0;
            wake_prev <= 1'b0;
            warm_go <= 1'b0;
            warm_reset <= 1'b1;
            resume_evt <= 1'b0;
            PC_HOLD <= 16'h0000;
        end else begin
            state <= next_state;
            wake_prev <= WAKE_PIN;
            warm_go <= warm_reset |
                       (state == S_STOP && next_state == S_WARM);
            warm_reset <= 1'b0;
            resume_evt <= (state != S_RUN) & (next_state == S_RUN);
            if (WR && state == S_RUN) begin
                case (ADDR)
                    `LPMC_A_SC1: begin
                        wake_release_style <= WDATA[`LPMC_SC1_WAKE_RELEASE_STYLE];
                        hold_en <= WDATA[`LPMC_SC1_HOLD];
                    end
                    `LPMC_A_SC2: begin
                        hf_en <= WDATA[`LPMC_SC2_HFEN];
                        lf_en <= WDATA[`LPMC_SC2_LFEN];
                        low_sel <= WDATA[`LPMC_SC2_LOW];
                    end
                    `LPMC_A_TBC: tb_sel <= WDATA[2:0];
                    `LPMC_A_WUC: wu_count <= WDATA;
                    default: ;
                endcase
            end
            if (state == S_RUN && next_state == S_STOP) begin
                stop_req <= 1'b1;
                ret_mode <= now_run;
                ret_hf <= hf_en;
                ret_lf <= lf_en;
                ret_low <= low_sel;
                PC_HOLD <= INSN_ADDR + 16'h0002;
            end
            if (state == S_WARM && next_state == S_RUN) begin
                stop_req <= 1'b0;
                hf_en <= ret_hf;
                lf_en <= ret_lf;
                low_sel <= ret_low;
            end
            if (state == S_TONLY && next_state == S_RUN && low_sel) begin
                hf_en <= 1'b0;
            end
        end
    end

    lpmc_warmup #(
        .UNIT(WU_UNIT)
    ) u_warm (
        .clk(CLK_SYS),
        .rst(rst_all),
        .start(warm_go),
        .count(wu_count),
        .done(warm_done)
    );

    // registered outputs
    always @(posedge CLK_SYS) begin
        if (rst_all) begin
            HF_OSC_EN <= 1'b1;
            LF_OSC_EN <= 1'b0;
            CORE_CLK_EN <= 1'b0;
            PERIPH_CLK_EN <= 1'b0;
            TBT_CLK_EN <= 1'b0;
            PERIPH_FREEZE <= 1'b0;
            RETAIN <= 1'b0;
            PORT_HOLD <= 1'b0;
            RESUME <= 1'b0;
            MODE <= `LPMC_M_WARM;
        end else begin
            MODE <= cur_mode;
            RESUME <= resume_evt;
            case (state)
                S_RUN: begin
                    HF_OSC_EN <= hf_en | ~low_sel;
                    LF_OSC_EN <= lf_en | low_sel;
                    CORE_CLK_EN <= 1'b1;
                    PERIPH_CLK_EN <= 1'b1;
                    TBT_CLK_EN <= 1'b1;
                    PERIPH_FREEZE <= 1'b0;
                    RETAIN <= 1'b0;
                    PORT_HOLD <= 1'b0;
                end
                S_TONLY: begin
                    HF_OSC_EN <= ~low_sel;
                    LF_OSC_EN <= lf_en | low_sel;
                    CORE_CLK_EN <= 1'b0;
                    PERIPH_CLK_EN <= 1'b0;
                    TBT_CLK_EN <= 1'b1;
                    PERIPH_FREEZE <= 1'b1;
                    RETAIN <= 1'b0;
                    PORT_HOLD <= 1'b0;
                end
                S_STOP: begin
                    HF_OSC_EN <= 1'b0;
                    LF_OSC_EN <= 1'b0;
                    CORE_CLK_EN <= 1'b0;
                    PERIPH_CLK_EN <= 1'b0;
                    TBT_CLK_EN <= 1'b0;
                    PERIPH_FREEZE <= 1'b1;
                    RETAIN <= 1'b1;
                    PORT_HOLD <= hold_en;
                end
                S_WARM: begin
                    HF_OSC_EN <= ret_hf | ~ret_low;
                    LF_OSC_EN <= ret_lf | ret_low;
                    CORE_CLK_EN <= 1'b0;
                    PERIPH_CLK_EN <= 1'b0;
                    TBT_CLK_EN <= 1'b0;
                    PERIPH_FREEZE <= stop_req;
                    RETAIN <= stop_req;
                    PORT_HOLD <= stop_req & hold_en;
                end
                default: begin
                    HF_OSC_EN <= 1'b1;
                    LF_OSC_EN <= 1'b0;
                    CORE_CLK_EN <= 1'b0;
                    PERIPH_CLK_EN <= 1'b0;
                    TBT_CLK_EN <= 1'b0;
                    PERIPH_FREEZE <= 1'b0;
                    RETAIN <= 1'b0;
                    PORT_HOLD <= 1'b0;
                end
            endcase
        end
    end

    // register read port, data valid the cycle after the strobe
    always @(posedge CLK_SYS) begin
        if (rst_all) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                `LPMC_A_SC1: RDATA <= {stop_req, wake_release_style, 1'b0, hold_en,
                                       4'h0};
                `LPMC_A_SC2: RDATA <= {hf_en, lf_en, low_sel, 2'h0,
                                       state == S_TONLY, 2'h0};
                `LPMC_A_TBC: RDATA <= {5'h00, tb_sel};
                `LPMC_A_WUC: RDATA <= wu_count;
                `LPMC_A_STAT: RDATA <= {ret_mode, 2'h0, cur_mode};
                `LPMC_A_DIV: RDATA <= div[7:0];
                default: RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end
endmodule // lpmc_top
`default_nettype wire

// file: verif/lpmc_checker.sv
// checker for lpmc_top: stop entry, wake and timer-only relations
// assumes a bind from tb and one clock domain on CLK_SYS
`timescale 1ns/10ps
`default_nettype none
module lpmc_checker (
    input wire CLK_SYS,
    input wire RST,
    input wire RESET_SRC,
    input wire [2:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire WAKE_PIN,
    input wire KEY_WAKE,
    input wire VOLT_WAKE,
    input wire HF_OSC_EN,
    input wire LF_OSC_EN,
    input wire CORE_CLK_EN,
    input wire PERIPH_CLK_EN,
    input wire TBT_CLK_EN,
    input wire PORT_HOLD,
    input wire RESUME,
    input wire [2:0] MODE
);
    wire go = WR && ADDR == 3'h0 && WDATA[7] && MODE <= 3'h3;
    wire take = go && !(WDATA[6] && WAKE_PIN);
    wire stp = MODE == 3'h6;
    wire sc2 = WR && ADDR == 3'h1 && WDATA[2];
    wire ens = HF_OSC_EN || LF_OSC_EN || CORE_CLK_EN || PERIPH_CLK_EN;
    reg sty = 1'b0;
    // release style of the last accepted stop request
    always @(posedge CLK_SYS)
        if (take) sty <= WDATA[6];
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST || RESET_SRC);
    AST_STOP_ENTER: assert property (
        take |-> ##2 stp) else $error("stop not entered");
    AST_STOP_REFUSE: assert property (
        go && WDATA[6] && WAKE_PIN |-> ##2 !stp) else $error("stop taken");
    AST_STOP_OFF: assert property (
        take |-> ##2 (!(ens || TBT_CLK_EN))[*2]) else $error("clock on");
    AST_STOP_HOLD: assert property (
        take |-> ##2 PORT_HOLD == $past(WDATA[4], 2)) else $error("hold");
    AST_EDGE_WAKE: assert property (
        stp && !sty && $rose(WAKE_PIN) |-> ##[1:3] MODE == 3'h7)
        else $error("edge wake missed");
    AST_LEVEL_WAKE: assert property (
        stp && sty && WAKE_PIN |-> ##[1:3] MODE == 3'h7)
        else $error("level wake missed");
    AST_SRC_WAKE: assert property (
        stp && (KEY_WAKE || VOLT_WAKE) |-> ##[1:3] MODE == 3'h7)
        else $error("key or voltage wake missed");
    AST_IDLE_ENTER: assert property (
        sc2 && WDATA[7:5] == 3'h4 && MODE == 3'h0 |-> ##2 MODE == 3'h4 &&
        TBT_CLK_EN && !CORE_CLK_EN && !PERIPH_CLK_EN) else $error("idle");
    AST_SLEEP_ENTER: assert property (
        sc2 && WDATA[7:5] == 3'h3 && MODE == 3'h3 |-> ##2 MODE == 3'h5 &&
        TBT_CLK_EN && LF_OSC_EN && !HF_OSC_EN && !CORE_CLK_EN)
        else $error("sleep");
    AST_SLEEP_EXIT: assert property (
        $fell(MODE == 3'h5) |-> MODE == 3'h3 && !HF_OSC_EN)
        else $error("sleep exit");
    AST_IDLE_EXIT: assert property (
        $fell(MODE == 3'h4) |-> MODE == 3'h0) else $error("idle exit");
    AST_RESUME_PULSE: assert property (
        RESUME |=> !RESUME) else $error("resume too long");
endmodule // lpmc_checker
`default_nettype wire

// file: verif/lpmc_wake_model.sv
// far side: low clock oscillator, wake pin, key, voltage and reset
// assumes requests change right after a CLK_SYS rising edge
`timescale 1ns/10ps
`default_nettype none
module lpmc_wake_model (
    input wire clk,
    input wire lf_en,
    input wire pin_req,
    input wire key_req,
    input wire volt_req,
    input wire rst_req,
    output logic lf_clk,
    output logic wake_pin,
    output logic key_wake,
    output logic volt_wake,
    output logic reset_src
);
    logic [1:0] ph = 2'h0;
    logic lf_r = 1'b0, pin_r = 1'b0, key_r = 1'b0;
    logic volt_r = 1'b0, rst_r = 1'b0;
    assign lf_clk = lf_r;
    assign wake_pin = pin_r;
    assign key_wake = key_r;
    assign volt_wake = volt_r;
    assign reset_src = rst_r;
    always @(posedge clk) begin
        ph <= ph + 2'h1;
        if (lf_en && ph == 2'h3)
            lf_r <= !lf_r;
        pin_r <= pin_req;
        key_r <= key_req;
        volt_r <= volt_req;
        rst_r <= rst_req;
    end
endmodule // lpmc_wake_model
`default_nettype wire

// file: verif/tb.sv
// testbench for lpmc_top: register port tasks and mode scenarios
// assumes lpmc_wake_model as far side and lpmc_checker bound in
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [2:0] ADDR = 3'h0;
    logic [7:0] WDATA = 8'h00;
    logic [15:0] INSN_ADDR = 16'h1230;
    logic pin_req = 1'b0, key_req = 1'b0, volt_req = 1'b0, rst_req = 1'b0;
    wire [7:0] RDATA;
    wire [15:0] PC_HOLD;
    wire [2:0] MODE;
    wire LF_CLK, WAKE_PIN, KEY_WAKE, VOLT_WAKE, RESET_SRC, HF_OSC_EN;
    wire LF_OSC_EN, CORE_CLK_EN, PERIPH_CLK_EN, TBT_CLK_EN, PERIPH_FREEZE;
    wire RETAIN, PORT_HOLD, RESUME;
    integer err_total = 0;
    integer n_compared = 0;
    always #10 CLK_SYS = !CLK_SYS;
    lpmc_top #(.DIV_W(16), .WU_UNIT(16'h0002)) i_lpmc_top (
        .CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .LF_CLK(LF_CLK),
        .WAKE_PIN(WAKE_PIN), .KEY_WAKE(KEY_WAKE), .VOLT_WAKE(VOLT_WAKE),
        .RESET_SRC(RESET_SRC), .INSN_ADDR(INSN_ADDR),
        .HF_OSC_EN(HF_OSC_EN), .LF_OSC_EN(LF_OSC_EN),
        .CORE_CLK_EN(CORE_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
        .TBT_CLK_EN(TBT_CLK_EN), .PERIPH_FREEZE(PERIPH_FREEZE),
        .RETAIN(RETAIN), .PORT_HOLD(PORT_HOLD), .PC_HOLD(PC_HOLD),
        .RESUME(RESUME), .MODE(MODE));
    lpmc_wake_model i_lpmc_wake_model (
        .clk(CLK_SYS), .lf_en(LF_OSC_EN), .pin_req(pin_req),
        .key_req(key_req), .volt_req(volt_req), .rst_req(rst_req),
        .lf_clk(LF_CLK), .wake_pin(WAKE_PIN), .key_wake(KEY_WAKE),
        .volt_wake(VOLT_WAKE), .reset_src(RESET_SRC));
    task close_out;
        begin
            $display("compared %0d mismatched %0d", n_compared, err_total);
            if (err_total == 0 && n_compared > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task chk(input [15:0] g, input [15:0] e);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge CLK_SYS);
            ADDR <= a;
            WDATA <= d;
            WR <= 1'b1;
            @(posedge CLK_SYS);
            WR <= 1'b0;
        end
    endtask
    task rd(input [2:0] a, input [7:0] e);
        begin
            @(posedge CLK_SYS);
            ADDR <= a;
            RD <= 1'b1;
            @(posedge CLK_SYS);
            RD <= 1'b0;
            #1 chk(RDATA, e);
        end
    endtask
    task wt(input [2:0] m);
        integer i;
        begin
            i = 0;
            #1;
            while (MODE !== m && i < 600) begin
                @(posedge CLK_SYS);
                #1 i = i + 1;
            end
            if (i == 600) begin
                err_total = err_total + 1;
                close_out;
            end else
                chk(MODE, m);
        end
    endtask
    // no interrupt sources are armed around stop
    task stop_wake(input [7:0] d, input [1:0] src, input [2:0] back);
        begin
            INSN_ADDR <= INSN_ADDR + 16'h0102;
            wr(3'h0, d);
            wt(3'h6);
            chk({HF_OSC_EN, LF_OSC_EN, CORE_CLK_EN, TBT_CLK_EN}, 4'h0);
            chk({RETAIN, PERIPH_FREEZE}, 2'h3);
            chk(PORT_HOLD, d[4]);
            chk(PC_HOLD, INSN_ADDR + 16'h0002);
            rd(3'h5, 8'h00);
            rd(3'h4, {back, 2'h0, 3'h6});
            case (src)
                2'h0: pin_req <= 1'b1;
                2'h1: key_req <= 1'b1;
                default: volt_req <= 1'b1;
            endcase
            wt(3'h7);
            {pin_req, key_req, volt_req} <= 3'h0;
            wt(back);
            chk({CORE_CLK_EN, RESUME}, 2'h3);
        end
    endtask
    initial begin
        repeat (5) @(posedge CLK_SYS);
        RST <= 1'b0;
        wt(3'h0);
        rd(3'h1, 8'h80);
        rd(3'h3, 8'h04);
        rd(3'h0, 8'h00);
        rd(3'h7, 8'h00);
        stop_wake(8'h80, 2'h0, 3'h0);
        stop_wake(8'h90, 2'h1, 3'h0);
        pin_req <= 1'b1;
        wr(3'h0, 8'hC0);
        repeat (3) @(posedge CLK_SYS);
        #1 chk(MODE, 3'h0);
        pin_req <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        stop_wake(8'hC0, 2'h0, 3'h0);
        wr(3'h2, 8'h04);
        wr(3'h1, 8'h84);
        wt(3'h4);
        chk({CORE_CLK_EN, PERIPH_CLK_EN, TBT_CLK_EN}, 3'h1);
        wt(3'h0);
        chk(RESUME, 1'b1);
        wr(3'h1, 8'hC0);
        wt(3'h1);
        wr(3'h1, 8'hC4);
        repeat (2) @(posedge CLK_SYS);
        #1 chk(MODE, 3'h1);
        rd(3'h1, 8'hC0);
        wr(3'h1, 8'hE0);
        wt(3'h2);
        chk({HF_OSC_EN, LF_OSC_EN, CORE_CLK_EN}, 3'h7);
        wr(3'h1, 8'h60); // gear changed only from run
        wt(3'h3);
        wr(3'h2, 8'h07);
        wr(3'h1, 8'h64);
        wt(3'h5);
        chk({HF_OSC_EN, LF_OSC_EN, TBT_CLK_EN}, 3'h3);
        chk(PERIPH_FREEZE, 1'b1);
        wt(3'h3);
        chk(HF_OSC_EN, 1'b0);
        stop_wake(8'h80, 2'h2, 3'h3);
        wr(3'h0, 8'h80);
        wt(3'h6);
        rst_req <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        rst_req <= 1'b0;
        wt(3'h0);
        close_out;
    end
endmodule // tb
bind lpmc_top lpmc_checker i_lpmc_checker (
    .CLK_SYS(CLK_SYS), .RST(RST), .RESET_SRC(RESET_SRC), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .WAKE_PIN(WAKE_PIN), .KEY_WAKE(KEY_WAKE),
    .VOLT_WAKE(VOLT_WAKE), .HF_OSC_EN(HF_OSC_EN), .LF_OSC_EN(LF_OSC_EN),
    .CORE_CLK_EN(CORE_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
    .TBT_CLK_EN(TBT_CLK_EN), .PORT_HOLD(PORT_HOLD), .RESUME(RESUME),
    .MODE(MODE));
`default_nettype wire
